// [hdl/rcs_pkg.sv]
package rcs_pkg;

    // ****************************************
    // Timing constants
    // ****************************************
    localparam int RCS_CLK_MHZ = 100;
    localparam int RCS_STRETCH_CYC = 512;
    localparam int RCS_RELEASE_CYC = 10;
    localparam int RCS_MOD_RESET_CYC = 4;
    localparam int RCS_BUS_WAIT_CYC = 64;
    localparam int RCS_CNT_W = 10;
    localparam logic [RCS_CNT_W-1:0] RCS_STRETCH_LAST = RCS_CNT_W'(RCS_STRETCH_CYC - 1);
    localparam logic [RCS_CNT_W-1:0] RCS_RELEASE_LAST = RCS_CNT_W'(RCS_RELEASE_CYC - 1);
    localparam logic [RCS_CNT_W-1:0] RCS_CNT_RST = 10'h000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        RCS_ST_POR,
        RCS_ST_RUN,
        RCS_ST_WAIT_BUS,
        RCS_ST_EXT_HELD,
        RCS_ST_DRIVE,
        RCS_ST_RELEASE
    } rcs_state_t;

    typedef struct packed {
        logic pin_o;
        logic pin_oe;
    } rcs_pin_t;

    typedef struct packed {
        logic [1:0] mode_bits;
        logic boot_sel;
    } rcs_cfg_t;

    localparam logic [1:0] RCS_MODE_RST = 2'h0;
    localparam logic RCS_BOOT_RST = 1'h0;

endpackage

// [hdl/rcs_reset_control_sequencer.sv]
`timescale 1ns/1ps
module rcs_reset_control_sequencer
    import rcs_pkg::*;
#(
    parameter int BUS_WAIT = RCS_BUS_WAIT_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    input wire logic int_reset_req,
    input wire logic catastrophic_req,
    input wire logic supply_ok,
    input wire logic pll_lock,
    input wire logic bus_cycle_active,
    input wire logic [1:0] mode_pins,
    input wire logic boot_pin,
    output logic [1:0] cfg_mode,
    output logic cfg_boot,
    output logic internal_reset,
    output logic module_reset,
    output logic cpu_abort,
    output logic cpu_start,
    output logic pins_inactive
);
    // ****************************************
    // Input synchronisation
    // ****************************************
    logic [5:0] raw_in;
    logic [5:0] syn_in;
    logic pin_s, lock_s, vok_s;
    logic [1:0] mode_s;
    logic boot_s;

    assign raw_in = {reset_pin_i, pll_lock, supply_ok, mode_pins, boot_pin};

    rcs_sync #(.W(6), .INIT(6'h01)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d(raw_in),
        .q(syn_in)
    );

    // Pin reads low at reset so a power-up is never taken as a released pin
    assign pin_s = syn_in[5];
    assign lock_s = syn_in[4];
    assign vok_s = syn_in[3];
    assign mode_s = syn_in[2:1];
    assign boot_s = syn_in[0];

    // ****************************************
    // Sequencer
    // ****************************************
    rcs_state_t st_r, st_nxt;
    logic [RCS_CNT_W-1:0] cnt_r, cnt_nxt;
    logic phase_r, phase_nxt;
    logic [15:0] wait_r, wait_nxt;
    logic [2:0] irst_cnt_r, irst_cnt_nxt;
    rcs_pin_t pin_r, pin_nxt;
    rcs_cfg_t cfg_r, cfg_nxt;
    logic irst_r, irst_nxt;
    logic mrst_r, mrst_nxt;
    logic abort_r, abort_nxt;
    logic start_r, start_nxt;
    logic inact_r, inact_nxt;
    logic last_cnt;

    // Shared counter, phase flag picks the terminal count
    assign last_cnt = phase_r ? (cnt_r == RCS_RELEASE_LAST) : (cnt_r == RCS_STRETCH_LAST);

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        phase_nxt = phase_r;
        wait_nxt = wait_r;
        pin_nxt = pin_r;
        cfg_nxt = cfg_r;
        irst_nxt = irst_r;
        abort_nxt = 1'b0;
        start_nxt = 1'b0;
        inact_nxt = inact_r;
        case (st_r)
            RCS_ST_POR: begin
                // Pin held low until supply good and PLL locked, then a drive period
                pin_nxt = '{pin_o: 1'b0, pin_oe: 1'b1};
                irst_nxt = !vok_s;
                cnt_nxt = RCS_CNT_RST;
                phase_nxt = 1'b0;
                if (vok_s && lock_s) begin
                    st_nxt = RCS_ST_DRIVE;
                end
            end
            RCS_ST_RUN: begin
                pin_nxt = '{pin_o: 1'b1, pin_oe: 1'b0};
                inact_nxt = 1'b0;
                wait_nxt = 16'h0000;
                if (catastrophic_req) begin
                    // Catastrophic requests skip the bus-cycle wait
                    st_nxt = RCS_ST_DRIVE;
                    abort_nxt = 1'b1;
                    cnt_nxt = RCS_CNT_RST;
                    phase_nxt = 1'b0;
                end else if (!pin_s || int_reset_req) begin
                    st_nxt = RCS_ST_WAIT_BUS;
                end
            end
            RCS_ST_WAIT_BUS: begin
                // Let a write finish, but never wait beyond the bus bound
                wait_nxt = wait_r + 16'h0001;
                if (!bus_cycle_active || catastrophic_req || wait_r >= 16'(BUS_WAIT - 1)) begin
                    abort_nxt = 1'b1;
                    irst_nxt = 1'b1;
                    inact_nxt = 1'b1;
                    cnt_nxt = RCS_CNT_RST;
                    phase_nxt = 1'b0;
                    st_nxt = pin_s ? RCS_ST_DRIVE : RCS_ST_EXT_HELD;
                end
            end
            RCS_ST_EXT_HELD: begin
                // Source still drives low; count starts once it lets go
                pin_nxt = '{pin_o: 1'b1, pin_oe: 1'b0};
                if (pin_s) begin
                    st_nxt = RCS_ST_DRIVE;
                    cnt_nxt = RCS_CNT_RST;
                    phase_nxt = 1'b0;
                end
            end
            RCS_ST_DRIVE: begin
                pin_nxt = '{pin_o: 1'b0, pin_oe: 1'b1};
                irst_nxt = 1'b1;
                inact_nxt = 1'b1;
                cfg_nxt = '{mode_bits: mode_s, boot_sel: boot_s};
                if (last_cnt && !int_reset_req) begin
                    st_nxt = RCS_ST_RELEASE;
                    cnt_nxt = RCS_CNT_RST;
                    phase_nxt = 1'b1;
                end else if (!last_cnt) begin
                    cnt_nxt = cnt_r + 10'h001;
                end
            end
            RCS_ST_RELEASE: begin
                pin_nxt = '{pin_o: 1'b1, pin_oe: 1'b0};
                if (last_cnt) begin
                    cnt_nxt = RCS_CNT_RST;
                    phase_nxt = 1'b0;
                    if (pin_s) begin
                        st_nxt = RCS_ST_RUN;
                        irst_nxt = 1'b0;
                        start_nxt = 1'b1;
                    end else begin
                        st_nxt = RCS_ST_DRIVE;
                    end
                end else begin
                    cnt_nxt = cnt_r + 10'h001;
                end
            end
            default: begin
                st_nxt = RCS_ST_POR;
            end
        endcase
        // Pin follows the next state, so drive and release line up with the shared counter
        if (st_nxt == RCS_ST_POR || st_nxt == RCS_ST_DRIVE) begin
            pin_nxt = '{pin_o: 1'b0, pin_oe: 1'b1};
        end else begin
            pin_nxt = '{pin_o: 1'b1, pin_oe: 1'b0};
        end
    end

    // Module reset after five cycles of internal reset
    always_comb begin
        irst_cnt_nxt = irst_cnt_r;
        mrst_nxt = mrst_r;
        if (!irst_r) begin
            irst_cnt_nxt = 3'h0;
            mrst_nxt = 1'b0;
        end else if (irst_cnt_r < 3'(RCS_MOD_RESET_CYC)) begin
            irst_cnt_nxt = irst_cnt_r + 3'h1;
        end else begin
            mrst_nxt = 1'b1;
        end
    end

    // No edges without a running clock, so nrst drives the pin low asynchronously
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= RCS_ST_POR;
            cnt_r <= RCS_CNT_RST;
            phase_r <= 1'b0;
            wait_r <= 16'h0000;
            irst_cnt_r <= 3'h0;
            pin_r <= '{pin_o: 1'b0, pin_oe: 1'b1};
            cfg_r <= '{mode_bits: RCS_MODE_RST, boot_sel: RCS_BOOT_RST};
            irst_r <= 1'b1;
            mrst_r <= 1'b1;
            abort_r <= 1'b0;
            start_r <= 1'b0;
            inact_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
            wait_r <= wait_nxt;
            irst_cnt_r <= irst_cnt_nxt;
            pin_r <= pin_nxt;
            cfg_r <= cfg_nxt;
            irst_r <= irst_nxt;
            mrst_r <= mrst_nxt;
            abort_r <= abort_nxt;
            start_r <= start_nxt;
            inact_r <= inact_nxt;
        end
    end

    assign reset_pin_o = pin_r.pin_o;
    assign reset_pin_oe = pin_r.pin_oe;
    assign cfg_mode = cfg_r.mode_bits;
    assign cfg_boot = cfg_r.boot_sel;
    assign internal_reset = irst_r;
    assign module_reset = mrst_r;
    assign cpu_abort = abort_r;
    assign cpu_start = start_r;
    assign pins_inactive = inact_r;

    // ****************************************
    // Assertions
    // ****************************************
    sequence drive_end_s;
        st_r == RCS_ST_DRIVE && last_cnt && !int_reset_req;
    endsequence

    sequence release_s;
        !reset_pin_oe [*8];
    endsequence

    drive_to_release_a: assert property (@(posedge clk) disable iff (!nrst)
        drive_end_s |=> release_s)
        else $error("pin not released after drive period");

    release_len_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == RCS_ST_RELEASE && cnt_r == RCS_RELEASE_LAST) |=> (st_r != RCS_ST_RELEASE))
        else $error("release phase wrong length");

    drive_min_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == RCS_ST_DRIVE && cnt_r < RCS_STRETCH_LAST) |=> (st_r == RCS_ST_DRIVE))
        else $error("drive ended early");

    int_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == RCS_ST_DRIVE && int_reset_req) |=> reset_pin_oe && !reset_pin_o)
        else $error("pin released with internal reset active");

    test_low_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == RCS_ST_RELEASE && last_cnt && !pin_s) |=> st_r == RCS_ST_DRIVE)
        else $error("low test did not redrive");

    ext_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == RCS_ST_EXT_HELD && pin_s) |=> (st_r == RCS_ST_DRIVE && cnt_r == RCS_CNT_RST))
        else $error("stretch not started on release");

    mod_reset_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(irst_r) |-> !mrst_r [*4])
        else $error("module reset too early");

    por_lock_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == RCS_ST_POR) |-> (reset_pin_oe && !reset_pin_o))
        else $error("pin released before lock");

    start_out_a: assert property (@(posedge clk) disable iff (!nrst)
        cpu_start |-> (st_r == RCS_ST_RUN && !internal_reset))
        else $error("start without reset exit");

    bus_wait_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == RCS_ST_WAIT_BUS) |-> ##[0:1000] (st_r != RCS_ST_WAIT_BUS))
        else $error("bus wait unbounded");
endmodule // rcs_reset_control_sequencer

// [hdl/rcs_sync.sv]
`timescale 1ns/1ps
// ****************************************
// Two-stage synchroniser
// ****************************************
module rcs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // rcs_sync

// [verif/rcs_ext_dev.sv]
`timescale 1ns/1ps
// ****************************************
// Far-side devices on the reset line
// ****************************************
module rcs_ext_dev (
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic ext_low,
    output logic pin
);
    // Open drain with pull-up: high whenever nobody sinks the line
    assign pin = ((pin_oe && !pin_o) || ext_low) ? 1'h0 : 1'h1;
endmodule // rcs_ext_dev

// [verif/rcs_reset_control_sequencer_tb.sv]
`timescale 1ns/1ps
module rcs_reset_control_sequencer_tb;
    import rcs_pkg::*;
    localparam int BW = 8;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic ext_low = 1'h0;
    logic int_req = 1'h0;
    logic cat_req = 1'h0;
    logic sup = 1'h0;
    logic lock = 1'h0;
    logic bus = 1'h0;
    logic boot = 1'h0;
    logic [1:0] mode = 2'h0;
    logic [1:0] cfg_mode;
    logic pin, pin_o, pin_oe, cfg_boot, int_rst, mod_rst, abort, start, inact, ab;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int d, L, b;
    logic ab_seen = 1'h0;

    always #5 clk = ~clk;

    // Abort can pulse long before the pin drive starts, so keep a sticky copy
    always @(negedge clk) begin
        if (abort === 1'h1) ab_seen = 1'h1;
    end

    rcs_reset_control_sequencer #(.BUS_WAIT(BW)) i_dut (.clk(clk), .nrst(nrst), .reset_pin_i(pin),
        .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .int_reset_req(int_req), .catastrophic_req(cat_req),
        .supply_ok(sup), .pll_lock(lock), .bus_cycle_active(bus), .mode_pins(mode), .boot_pin(boot),
        .cfg_mode(cfg_mode), .cfg_boot(cfg_boot), .internal_reset(int_rst), .module_reset(mod_rst),
        .cpu_abort(abort), .cpu_start(start), .pins_inactive(inact));

    rcs_ext_dev i_ext (.pin_o(pin_o), .pin_oe(pin_oe), .ext_low(ext_low), .pin(pin));

    // ****************************************
    // Checks and report
    // ****************************************
    task automatic chk_v(input logic [2:0] got, input logic [2:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t %s", $time, m);
        end
    endtask

    task automatic chk_n(input int got, input int lo, input int hi, input string m);
        n_compared++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("BAD t=%0t %s got %0d", $time, m, got);
        end
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            $display("BAD t=%0t timeout", $time);
            final_report();
        end
    end

    // ****************************************
    // Drivers
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic new_test;
        tick(20);
        ab_seen = 1'h0;
        {mode, boot} = 3'($urandom);
    endtask

    // Cycles until the pin drive starts; notes any abort pulse on the way
    task automatic wait_oe(output int n, output logic seen);
        n = 0;
        seen = 1'h0;
        @(negedge clk);
        while (pin_oe !== 1'h1 && n < 2000) begin
            if (abort === 1'h1) seen = 1'h1;
            @(negedge clk);
            n++;
        end
        if (ab_seen === 1'h1 || abort === 1'h1) seen = 1'h1;
    endtask

    task automatic measure(input int lo, input int hi, input string name);
        int drv;
        int rel;
        drv = 0;
        rel = 0;
        while (pin_oe === 1'h1 && drv < 3000) begin
            if (drv == 10) chk_v({mod_rst, inact, pin_o}, 3'h6, "outputs in drive");
            @(negedge clk);
            drv++;
        end
        chk_n(drv, lo, hi, "drive length");
        while (start !== 1'h1 && rel < 20) begin
            @(negedge clk);
            rel++;
        end
        chk_n(rel, 10, 10, "release length");
        chk_v({cfg_mode, cfg_boot}, {mode, boot}, "straps");
        $display("test %s done", name);
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        void'($urandom(32'h6F669372));
        {mode, boot} = 3'($urandom);
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'h1;
        tick(5);
        chk_v({pin_oe, int_rst}, 3'h3, "power-on hold");
        sup = 1'h1;
        lock = 1'h1;
        measure(512, 516, "power_on");
        // External requests; the second one keeps the line low into the test
        for (int k = 0; k < 2; k++) begin
            new_test();
            ext_low = 1'h1;
            tick(20 + $urandom % 40);
            chk_v(pin_oe, 1'h0, "no drive while held");
            ext_low = 1'h0;
            wait_oe(d, ab);
            chk_n(d, 1, 8, "external delay");
            chk_v(ab, 1'h1, "abort");
            if (k == 1) begin
                while (pin_oe === 1'h1) @(negedge clk);
                tick(1);
                ext_low = 1'h1;
                wait_oe(d, ab);
                tick(1);
                ext_low = 1'h0;
                chk_n(d, 9, 11, "retest redrive");
            end
            measure(512, 512, "external");
        end
        // Internal requests, short and longer than the stretch
        for (int k = 0; k < 2; k++) begin
            new_test();
            L = (k == 0) ? 3 : 520 + $urandom % 200;
            int_req = 1'h1;
            fork
                begin
                    tick(L);
                    int_req = 1'h0;
                end
            join_none
            wait_oe(d, ab);
            chk_v(ab, 1'h1, "abort");
            measure(k == 0 ? 512 : L - 6, k == 0 ? 512 : L + 2, "internal");
        end
        // Open bus cycles delay a request; the last pass is catastrophic
        for (int k = 0; k < 4; k++) begin
            new_test();
            b = (k == 3) ? 20 : $urandom % 13;
            bus = 1'h1;
            if (k == 3) cat_req = 1'h1;
            else int_req = 1'h1;
            tick(1);
            int_req = 1'h0;
            cat_req = 1'h0;
            fork
                begin
                    tick(b);
                    bus = 1'h0;
                end
            join_none
            wait_oe(d, ab);
            if (k == 3) chk_n(d, 0, 3, "catastrophic delay");
            else chk_n(d, b < BW ? b : BW, (b < BW ? b : BW) + 5, "bus wait");
            measure(512, 512, "bus_wait");
        end
        final_report();
    end
endmodule // rcs_reset_control_sequencer_tb
